// File: verilog/rlc_pkg.sv
package rlc_pkg;

    // Byte offsets of the lane slice and the shared control register.
    localparam logic [7:0] RLC_OFS_DETECT_OVR = 8'h22;
    localparam logic [7:0] RLC_OFS_MUTE_DETECT = 8'h23;
    localparam logic [7:0] RLC_OFS_INPUT_BOOST = 8'h24;
    localparam logic [7:0] RLC_OFS_OUTPUT_SWING = 8'h25;
    localparam logic [7:0] RLC_OFS_EMPH_STATUS = 8'h26;
    localparam logic [7:0] RLC_OFS_IDLE_THRESH = 8'h27;
    localparam logic [7:0] RLC_OFS_SHARED_DETECT = 8'h28;
    localparam logic [7:0] RLC_OFS_SPARE = 8'h29;

    // Reset values.
    localparam logic [7:0] RLC_RST_DETECT_OVR = 8'h00;
    localparam logic [7:0] RLC_RST_MUTE_DETECT = 8'h00;
    localparam logic [7:0] RLC_RST_INPUT_BOOST = 8'h2f;
    localparam logic [7:0] RLC_RST_OUTPUT_SWING = 8'had;
    localparam logic [7:0] RLC_RST_EMPH_STATUS = 8'h02;
    localparam logic [7:0] RLC_RST_IDLE_THRESH = 8'h00;
    localparam logic [7:0] RLC_RST_SHARED_DETECT = 8'h0c;
    localparam logic [7:0] RLC_RST_SPARE = 8'h00;
    localparam logic [7:0] RLC_ZERO_BYTE = 8'h00;

    // Field positions.
    localparam int RLC_BIT_FORCE_OFF = 2;
    localparam int RLC_BIT_FORCE_ON = 1;
    localparam int RLC_BIT_MUTE_MANUAL_EN = 5;
    localparam int RLC_BIT_MUTE_MANUAL = 4;
    localparam int RLC_POS_POLICY = 2;
    localparam int RLC_BIT_SHORT_PROT = 7;
    localparam int RLC_BIT_GEN12 = 6;
    localparam int RLC_POS_LEVEL = 0;
    localparam int RLC_BIT_FOUND = 7;
    localparam int RLC_POS_RATE = 5;
    localparam int RLC_POS_ASSERT_TH = 2;
    localparam int RLC_POS_DEASSERT_TH = 0;
    localparam int RLC_POS_HIGH_THR = 4;
    localparam int RLC_POS_FAST_OOB = 2;
    localparam int RLC_POS_GAIN_RED = 0;
    // Only the de-emphasis code and the reserved pair above it are writable.
    localparam logic [7:0] RLC_EMPH_WR_MASK = 8'h1f;

    // Receiver probe policy codes.
    localparam logic [1:0] RLC_POL_HIGH_Z = 2'h0;
    localparam logic [1:0] RLC_POL_PROBE_WINDOW = 2'h1;
    localparam logic [1:0] RLC_POL_PROBE_FOREVER = 2'h2;
    localparam logic [1:0] RLC_POL_TERM_50 = 2'h3;
    localparam logic [1:0] RLC_RATE_NO_MEANING = 2'h0;

    // Probe timing derived from the clock rate.
    localparam int RLC_CLK_FREQ_HZ = 25_000_000;
    localparam int RLC_PROBE_PERIOD_MS = 12;
    localparam int RLC_PROBE_WINDOW_MS = 600;
    localparam int RLC_PROBE_CYCLES = RLC_PROBE_PERIOD_MS * (RLC_CLK_FREQ_HZ / 1000);
    localparam int RLC_PROBE_ATTEMPTS = RLC_PROBE_WINDOW_MS / RLC_PROBE_PERIOD_MS;
    localparam int RLC_TIMER_W = 24;
    localparam int RLC_ATTEMPT_W = 6;

    // One-hot probe sequencer states.
    typedef enum logic [3:0] {
        PR_HOLD = 4'h1,
        PR_PROBE = 4'h2,
        PR_FOUND = 4'h4,
        PR_STOP = 4'h8
    } rlc_probe_e;

    // Register access from the serial management engine.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rlc_bus_req_s;

    // Byte delivered by the configuration memory loader.
    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [7:0] data;
    } rlc_load_s;

    // Settings presented to the lane's analog front end.
    typedef struct packed {
        logic [7:0] input_boost_level;
        logic [2:0] output_swing_level;
        logic short_prot_en;
        logic gen12_mode;
        logic [2:0] deemphasis_level;
        logic [1:0] idle_assert_th;
        logic [1:0] idle_deassert_th;
    } rlc_lane_cfg_s;

    // Group-wide signal-detect settings, index 1 is lanes 0-3, index 0 lanes 4-7.
    typedef struct packed {
        logic [1:0] high_thr_en;
        logic [1:0] fast_oob_en;
        logic [1:0] detect_gain_reduce;
    } rlc_shared_cfg_s;

    // Whole state of the register slice.
    typedef struct packed {
        logic [7:0] detect_ovr;
        logic [7:0] mute_detect;
        logic [7:0] boost;
        logic [7:0] swing;
        logic [7:0] emph;
        logic [7:0] thresh;
        logic [7:0] shared;
        logic [7:0] spare;
        logic own_policy;
        logic own_rate;
        logic own_thresh;
        rlc_probe_e probe_st;
        logic [1:0] last_policy;
        logic [RLC_TIMER_W-1:0] timer;
        logic [RLC_ATTEMPT_W-1:0] attempts;
        logic found;
        logic probe_pulse;
        logic [7:0] rd_data;
        logic rd_valid;
    } rlc_state_s;

endpackage : rlc_pkg

// File: verilog/rlc_lane_regs.sv
`timescale 1ns/1ps

// Function
// RULE1: Manual-enable bit selects manual or automatic muting.
// RULE2: Manual mute bit forces idle or active.
// RULE3: Policy 00 high impedance, 11 fixed termination.
// RULE4: Policy 01 probes 50 times, then stops.
// RULE5: Policy 10 probes every period until found.
// RULE6: Automatic policies terminate only after detection.
// RULE7: Register policy overrides the policy strap pin.
// RULE8: Eight-bit input boost, reset value 2f.
// RULE9: Swing bit 7 enables short-circuit protection.
// RULE10: Swing bit 6 selects rate class, overrides pin.
// RULE11: Software keeps swing bits 5:3 at 101.
// RULE12: Three-bit swing code, default 101.
// RULE13: Status bit 7 reports receiver found.
// RULE14: Status bits 6:5 report detected rate.
// RULE15: Rate status meaningful only in automatic strap.
// RULE16: Three-bit de-emphasis code, default 010.
// RULE17: Two-bit assert threshold code, default 00.
// RULE18: Two-bit deassert threshold code, default 00.
// RULE19: Register thresholds override the threshold strap pin.
// RULE20: Shared bits 5 and 4 raise threshold range.
// RULE21: Shared bits 3 and 2 enable fast idle.
// RULE22: Shared bits 1 and 0 reduce detect gain.
// RULE23: Software writes reserved bits as zero.
// RULE24: Memory loader fills registers before management writes.
// RULE25: Per-lane force-off and force-on detect bits.
module rlc_lane_regs
    import rlc_pkg::*;
#(
    parameter int PROBE_CYCLES = RLC_PROBE_CYCLES,
    parameter int PROBE_ATTEMPTS = RLC_PROBE_ATTEMPTS
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire rlc_bus_req_s bus_req_i,
    output logic [7:0] bus_rdata_o,
    output logic bus_rvalid_o,
    input wire logic cfg_load_mode_i,
    input wire rlc_load_s load_i,
    input wire logic load_done_i,
    input wire logic [1:0] receiver_probe_strap_i,
    input wire logic rate_pin_gen12_i,
    input wire logic rate_pin_auto_i,
    input wire logic [1:0] threshold_strap_pin_i,
    input wire logic auto_idle_i,
    input wire logic rx_present_i,
    input wire logic [1:0] detected_rate_i,
    input wire logic raw_detect_i,
    output logic mute_o,
    output logic term_50_o,
    output logic probe_o,
    output logic receiver_found_flag_o,
    output logic sig_detect_o,
    output logic detect_force_off_o,
    output logic detect_force_on_o,
    output rlc_lane_cfg_s lane_cfg_o,
    output rlc_shared_cfg_s shared_cfg_o
);

    // Registered state and its next value.
    rlc_state_s st;
    rlc_state_s next_st;
    // Policy in force after the register-over-strap choice.
    logic [1:0] eff_policy;
    // Management writes are held off while the loader still owns the registers.
    logic smbus_blocked;
    // Helper for the probe spacing check.
    logic [RLC_TIMER_W:0] gap_cnt;

    // Storing a byte: shared by the loader and the management engine.
    function automatic rlc_state_s apply_write(input rlc_state_s s, input logic [7:0] addr,
                                               input logic [7:0] data);
        rlc_state_s r;
        r = s;
        if (addr == RLC_OFS_DETECT_OVR) begin
            r.detect_ovr = data;
        end else if (addr == RLC_OFS_MUTE_DETECT) begin
            r.mute_detect = data;
            r.own_policy = 1'b1; // RULE7
        end else if (addr == RLC_OFS_INPUT_BOOST) begin
            r.boost = data; // RULE8
        end else if (addr == RLC_OFS_OUTPUT_SWING) begin
            // Bits 5:3 are stored as written; software must keep them at 101.
            r.swing = data; // RULE11
            r.own_rate = 1'b1; // RULE10
        end else if (addr == RLC_OFS_EMPH_STATUS) begin
            r.emph = data & RLC_EMPH_WR_MASK;
        end else if (addr == RLC_OFS_IDLE_THRESH) begin
            r.thresh = data;
            r.own_thresh = 1'b1; // RULE19
        end else if (addr == RLC_OFS_SHARED_DETECT) begin
            r.shared = data;
        end else if (addr == RLC_OFS_SPARE) begin
            r.spare = data;
        end
        return r;
    endfunction : apply_write

    // Read mux; an unmapped offset answers zero.
    function automatic logic [7:0] read_byte(input rlc_state_s s, input logic [7:0] addr,
                                             input logic [1:0] rate);
        logic [7:0] d;
        d = RLC_ZERO_BYTE;
        if (addr == RLC_OFS_DETECT_OVR) begin
            d = s.detect_ovr;
        end else if (addr == RLC_OFS_MUTE_DETECT) begin
            d = s.mute_detect;
        end else if (addr == RLC_OFS_INPUT_BOOST) begin
            d = s.boost;
        end else if (addr == RLC_OFS_OUTPUT_SWING) begin
            d = s.swing;
        end else if (addr == RLC_OFS_EMPH_STATUS) begin
            d = s.emph;
            d[RLC_BIT_FOUND] = s.found; // RULE13
            d[RLC_POS_RATE+:2] = rate; // RULE14
        end else if (addr == RLC_OFS_IDLE_THRESH) begin
            d = s.thresh;
        end else if (addr == RLC_OFS_SHARED_DETECT) begin
            d = s.shared;
        end else if (addr == RLC_OFS_SPARE) begin
            d = s.spare;
        end
        return d;
    endfunction : read_byte

    // Reset image of the whole state.
    localparam rlc_state_s ST_RESET = '{
        detect_ovr: RLC_RST_DETECT_OVR,
        mute_detect: RLC_RST_MUTE_DETECT,
        boost: RLC_RST_INPUT_BOOST,
        swing: RLC_RST_OUTPUT_SWING,
        emph: RLC_RST_EMPH_STATUS,
        thresh: RLC_RST_IDLE_THRESH,
        shared: RLC_RST_SHARED_DETECT,
        spare: RLC_RST_SPARE,
        own_policy: 1'b0,
        own_rate: 1'b0,
        own_thresh: 1'b0,
        probe_st: PR_HOLD,
        last_policy: RLC_POL_HIGH_Z,
        timer: '0,
        attempts: '0,
        found: 1'b0,
        probe_pulse: 1'b0,
        rd_data: RLC_ZERO_BYTE,
        rd_valid: 1'b0
    };

    // Until software or the loader writes the policy, the strap pin rules.
    assign eff_policy = st.own_policy ? st.mute_detect[RLC_POS_POLICY+:2]
                                      : receiver_probe_strap_i; // RULE7
    // Load mode keeps management writes off until the loader reports done.
    assign smbus_blocked = cfg_load_mode_i & ~load_done_i; // RULE24

    // Next-state logic: register writes, reads and the probe sequencer.
    always_comb begin
        next_st = st;
        next_st.probe_pulse = 1'b0;
        next_st.rd_valid = 1'b0;
        // Loader bytes land only in load mode; management bytes only when not blocked.
        if (cfg_load_mode_i && load_i.valid) begin
            next_st = apply_write(next_st, load_i.addr, load_i.data); // RULE24
        end
        if (bus_req_i.wr && !smbus_blocked) begin
            next_st = apply_write(next_st, bus_req_i.addr, bus_req_i.wdata);
        end
        // Reads are answered one cycle later from a flop.
        if (bus_req_i.rd) begin
            next_st.rd_valid = 1'b1;
            next_st.rd_data = read_byte(st, bus_req_i.addr,
                                        rate_pin_auto_i ? detected_rate_i
                                                        : RLC_RATE_NO_MEANING); // RULE15
        end
        next_st.last_policy = eff_policy;
        // A policy change restarts detection from scratch.
        if (eff_policy != st.last_policy) begin
            next_st.found = 1'b0;
            next_st.attempts = '0;
            next_st.timer = RLC_TIMER_W'(PROBE_CYCLES - 1);
            if (eff_policy == RLC_POL_PROBE_WINDOW || eff_policy == RLC_POL_PROBE_FOREVER) begin
                next_st.probe_st = PR_PROBE;
            end else begin
                next_st.probe_st = PR_HOLD; // RULE3
            end
        end else begin
            case (st.probe_st)
                // Static policies: nothing to time.
                PR_HOLD: begin
                    next_st.found = 1'b0;
                end
                // Count one period, then fire a probe and sample the answer.
                PR_PROBE: begin
                    if (st.timer != '0) begin
                        next_st.timer = st.timer - 1'b1;
                    end else begin
                        next_st.timer = RLC_TIMER_W'(PROBE_CYCLES - 1);
                        next_st.probe_pulse = 1'b1; // RULE5
                        next_st.attempts = st.attempts + 1'b1;
                    end
                    // The far end answers while the pulse stands, not before it goes out.
                    if (st.probe_pulse) begin
                        if (rx_present_i) begin
                            next_st.found = 1'b1; // RULE6
                            next_st.probe_st = PR_FOUND;
                        end else if (eff_policy == RLC_POL_PROBE_WINDOW &&
                                     st.attempts == RLC_ATTEMPT_W'(PROBE_ATTEMPTS)) begin
                            next_st.probe_st = PR_STOP; // RULE4
                        end
                    end
                end
                // Receiver seen: termination stays on.
                PR_FOUND: begin
                    next_st.found = 1'b1;
                end
                // Window used up without a receiver; only a policy change restarts.
                PR_STOP: begin
                    next_st.found = 1'b0;
                end
                default: begin
                    next_st.probe_st = PR_HOLD;
                end
            endcase
        end
    end

    // State register.
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Read answer.
    assign bus_rdata_o = st.rd_data;
    assign bus_rvalid_o = st.rd_valid;

    // Manual control wins only when enabled; otherwise the idle detector decides.
    assign mute_o = st.mute_detect[RLC_BIT_MUTE_MANUAL_EN] ? st.mute_detect[RLC_BIT_MUTE_MANUAL]
                                                           : auto_idle_i; // RULE1 RULE2
    // Termination: fixed by policy 11, or after a successful probe.
    assign term_50_o = (eff_policy == RLC_POL_TERM_50) ||
                       (st.probe_st == PR_FOUND); // RULE3 RULE6
    assign probe_o = st.probe_pulse;
    assign receiver_found_flag_o = st.found; // RULE13

    // Detect override: forcing off beats forcing on when both are set.
    assign detect_force_off_o = st.detect_ovr[RLC_BIT_FORCE_OFF]; // RULE25
    assign detect_force_on_o = st.detect_ovr[RLC_BIT_FORCE_ON];
    assign sig_detect_o = detect_force_off_o ? 1'b0 : (detect_force_on_o | raw_detect_i);

    // Analog settings from the stored fields, straps where not yet owned.
    always_comb begin
        lane_cfg_o.input_boost_level = st.boost; // RULE8
        lane_cfg_o.output_swing_level = st.swing[RLC_POS_LEVEL+:3]; // RULE12
        lane_cfg_o.short_prot_en = st.swing[RLC_BIT_SHORT_PROT]; // RULE9
        lane_cfg_o.gen12_mode = st.own_rate ? st.swing[RLC_BIT_GEN12]
                                            : rate_pin_gen12_i; // RULE10
        lane_cfg_o.deemphasis_level = st.emph[RLC_POS_LEVEL+:3]; // RULE16
        lane_cfg_o.idle_assert_th = st.own_thresh ? st.thresh[RLC_POS_ASSERT_TH+:2]
                                                  : threshold_strap_pin_i; // RULE17 RULE19
        lane_cfg_o.idle_deassert_th = st.own_thresh ? st.thresh[RLC_POS_DEASSERT_TH+:2]
                                                    : threshold_strap_pin_i; // RULE18
        shared_cfg_o.high_thr_en = st.shared[RLC_POS_HIGH_THR+:2]; // RULE20
        shared_cfg_o.fast_oob_en = st.shared[RLC_POS_FAST_OOB+:2]; // RULE21
        shared_cfg_o.detect_gain_reduce = st.shared[RLC_POS_GAIN_RED+:2]; // RULE22
    end

    // Cycles since the last probe while probing; read only by a check below.
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gap_cnt <= '0;
        end else if (probe_o || st.probe_st != PR_PROBE) begin
            gap_cnt <= '0;
        end else begin
            gap_cnt <= gap_cnt + 1'b1;
        end
    end

    // Manual mute honoured once manual enable has held two cycles running.
    sequence s_manual_on;
        st.mute_detect[RLC_BIT_MUTE_MANUAL_EN] [*2];
    endsequence
    property p_mute_manual;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        s_manual_on |-> mute_o == st.mute_detect[RLC_BIT_MUTE_MANUAL];
    endproperty
    a_mute_manual: assert property (p_mute_manual) else $error("manual mute ignored"); // RULE2

    // Without manual enable the idle detector drives muting.
    property p_mute_auto;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        !st.mute_detect[RLC_BIT_MUTE_MANUAL_EN] |-> mute_o == auto_idle_i;
    endproperty
    a_mute_auto: assert property (p_mute_auto) else $error("auto mute not followed"); // RULE1

    // The high-impedance policy never probes and leaves termination off.
    property p_static_policy;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        (eff_policy == RLC_POL_HIGH_Z && $stable(eff_policy)) |=>
            (!probe_o && (term_50_o == (eff_policy == RLC_POL_TERM_50)));
    endproperty
    a_static_policy: assert property (p_static_policy) else $error("high-z probed"); // RULE3

    // The window policy never exceeds its attempt count.
    property p_attempt_cap;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        (eff_policy == RLC_POL_PROBE_WINDOW) |-> st.attempts <= RLC_ATTEMPT_W'(PROBE_ATTEMPTS);
    endproperty
    a_attempt_cap: assert property (p_attempt_cap) else $error("too many probes"); // RULE4

    // Probes are spaced by at most one period while searching.
    property p_probe_gap;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        (st.probe_st == PR_PROBE) |-> gap_cnt <= (RLC_TIMER_W + 1)'(PROBE_CYCLES);
    endproperty
    a_probe_gap: assert property (p_probe_gap) else $error("probe period overrun"); // RULE5

    // Automatic policies terminate only once a receiver was found.
    property p_term_after_found;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        (eff_policy != RLC_POL_TERM_50 && term_50_o) |-> receiver_found_flag_o;
    endproperty
    a_term_after_found: assert property (p_term_after_found) else $error("early term"); // RULE6

    // A management write to the boost register shows on the next cycle.
    property p_boost_write;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        (bus_req_i.wr && !smbus_blocked && bus_req_i.addr == RLC_OFS_INPUT_BOOST &&
         !(cfg_load_mode_i && load_i.valid)) |=>
            lane_cfg_o.input_boost_level == $past(bus_req_i.wdata);
    endproperty
    a_boost_write: assert property (p_boost_write) else $error("boost not stored"); // RULE8

    // A status read returns the found flag of the request cycle.
    property p_found_read;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        (bus_req_i.rd && bus_req_i.addr == RLC_OFS_EMPH_STATUS) |=>
            (bus_rvalid_o && bus_rdata_o[RLC_BIT_FOUND] == $past(st.found));
    endproperty
    a_found_read: assert property (p_found_read) else $error("found flag misread"); // RULE13

    // Forcing detection off wins over everything.
    property p_force_off;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        detect_force_off_o |-> !sig_detect_o;
    endproperty
    a_force_off: assert property (p_force_off) else $error("detect not forced off"); // RULE25

    // A receiver that answers a probe is latched on the next edge.
    property p_found_on_answer;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        (st.probe_st == PR_PROBE && probe_o && rx_present_i && eff_policy == st.last_policy)
            |=> receiver_found_flag_o;
    endproperty
    a_found_on_answer: assert property (p_found_on_answer) else $error("answer lost"); // RULE6

    // A used-up window stays silent until the policy changes.
    property p_window_stop;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        (st.probe_st == PR_STOP) |-> !probe_o;
    endproperty
    a_window_stop: assert property (p_window_stop) else $error("probe after window"); // RULE4

    // Outside the automatic strap the rate field reads as zero.
    property p_rate_hidden;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        (bus_req_i.rd && bus_req_i.addr == RLC_OFS_EMPH_STATUS && !rate_pin_auto_i) |=>
            bus_rdata_o[RLC_POS_RATE+:2] == RLC_RATE_NO_MEANING;
    endproperty
    a_rate_hidden: assert property (p_rate_hidden) else $error("rate not hidden"); // RULE15

endmodule : rlc_lane_regs

// File: dv/rlc_host_model.sv
`timescale 1ns/1ps
// Management host plus the far-end receiver, as seen from the lane slice.
module rlc_host_model
    import rlc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic probe_i,
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i,
    output rlc_bus_req_s req_o,
    output logic rx_present_o
);
    logic present = 1'b0; // High once a receiver is fitted at the far end.
    logic junk = 1'b0; // Changing level shown while nobody probes.
    // The answer means nothing outside a probe, so it must not sit still.
    always @(posedge sys_clk_i) begin
        junk <= ~junk;
    end
    assign rx_present_o = probe_i ? present : junk;
    initial req_o = '0;
    // One-cycle write strobe, launched at a falling edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_i) req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge sys_clk_i) req_o = '0;
    endtask : wr
    // Read strobe; the answer stands one cycle, so it is taken at the next falling edge.
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(negedge sys_clk_i) req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge sys_clk_i);
        ok = rvalid_i;
        d = rdata_i;
        req_o = '0;
    endtask : rd
endmodule : rlc_host_model

// File: dv/rlc_lane_regs_test.sv
`timescale 1ns/1ps
// Self-checking bench for the lane register slice.
module rlc_lane_regs_test
    import rlc_pkg::*;
;
    logic sys_clk = 1'b0, arst_n = 1'b0, load_mode = 1'b1, load_done = 1'b0;
    logic gen12_pin = 1'b0, auto_pin = 1'b0, auto_idle = 1'b0, raw_det = 1'b0;
    logic [1:0] pol_strap = 2'h3, th_strap = 2'h1, det_rate = 2'h3;
    rlc_load_s load = '0; // Configuration memory loader stand-in.
    rlc_bus_req_s req;
    logic [7:0] rdata;
    logic rx_pres, rvalid, mute, term, probe, found, sdet, foff, fon;
    rlc_lane_cfg_s lcfg;
    rlc_shared_cfg_s scfg;
    int n_errors = 0, total_checks = 0;
    // 25 MHz clock.
    always #20 sys_clk = ~sys_clk;
    // Short probe counts keep the run brief.
    rlc_lane_regs #(.PROBE_CYCLES(20), .PROBE_ATTEMPTS(3)) rlc_lane_regs_i (
        .sys_clk_i(sys_clk), .arst_n_i(arst_n), .bus_req_i(req), .bus_rdata_o(rdata),
        .bus_rvalid_o(rvalid), .cfg_load_mode_i(load_mode), .load_i(load),
        .load_done_i(load_done), .receiver_probe_strap_i(pol_strap),
        .rate_pin_gen12_i(gen12_pin), .rate_pin_auto_i(auto_pin),
        .threshold_strap_pin_i(th_strap), .auto_idle_i(auto_idle), .rx_present_i(rx_pres),
        .detected_rate_i(det_rate), .raw_detect_i(raw_det), .mute_o(mute), .term_50_o(term),
        .probe_o(probe), .receiver_found_flag_o(found), .sig_detect_o(sdet),
        .detect_force_off_o(foff), .detect_force_on_o(fon), .lane_cfg_o(lcfg),
        .shared_cfg_o(scfg));
    rlc_host_model host_i (
        .sys_clk_i(sys_clk), .probe_i(probe), .rdata_i(rdata), .rvalid_i(rvalid),
        .req_o(req), .rx_present_o(rx_pres));
    // Compares one byte and counts the outcome.
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // Reads a register and compares both the answer strobe and the byte.
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        host_i.rd(a, d, ok);
        chk("read valid", {7'h0, ok}, 8'h01);
        chk($sformatf("reg %h", a), d, exp);
    endtask : rchk
    // Counts probe pulses over a window of cycles.
    task automatic count_probes(input int cyc, input logic [7:0] exp);
        int n = 0;
        repeat (cyc) begin
            @(negedge sys_clk);
            if (probe === 1'b1) n++;
        end
        chk("probe count", 8'(n), exp);
    endtask : count_probes
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : stop_test
    // Reset table, unmapped read, and the loader winning before it is done.
    task automatic t_reset_load();
        logic [7:0] rst [8] = '{8'h00, 8'h00, 8'h2f, 8'had, 8'h02, 8'h00, 8'h0c, 8'h00};
        for (int i = 0; i < 8; i++) rchk(8'h22 + 8'(i), rst[i]);
        rchk(8'h40, 8'h00);
        @(negedge sys_clk) load = '{valid: 1'b1, addr: 8'h24, data: 8'h11};
        @(negedge sys_clk) load = '0;
        host_i.wr(8'h24, 8'h99);
        rchk(8'h24, 8'h11);
        load_done = 1'b1;
    endtask : t_reset_load
    // Field decoding and register precedence over the straps.
    task automatic t_fields();
        gen12_pin = 1'b1;
        host_i.wr(8'h25, 8'h2b);
        chk("swing", {lcfg.short_prot_en, lcfg.gen12_mode, 3'h0, lcfg.output_swing_level},
            8'h03);
        host_i.wr(8'h25, 8'hec);
        chk("swing", {lcfg.short_prot_en, lcfg.gen12_mode, 3'h0, lcfg.output_swing_level},
            8'hc4);
        host_i.wr(8'h24, 8'h55);
        chk("boost", lcfg.input_boost_level, 8'h55);
        host_i.wr(8'h27, 8'h0b);
        chk("thresh", {4'h0, lcfg.idle_assert_th, lcfg.idle_deassert_th}, 8'h0b);
        host_i.wr(8'h28, 8'h2a);
        chk("shared", {2'h0, scfg}, 8'h2a);
        host_i.wr(8'h28, 8'h15);
        chk("shared", {2'h0, scfg}, 8'h15);
        host_i.wr(8'h26, 8'h07);
        chk("deemph", {5'h0, lcfg.deemphasis_level}, 8'h07);
        auto_pin = 1'b1;
        rchk(8'h26, 8'h67);
        auto_pin = 1'b0;
        rchk(8'h26, 8'h07);
    endtask : t_fields
    // Every combination of manual enable, manual mute and automatic idle.
    task automatic t_mute();
        chk("term strap", {7'h0, term}, 8'h01);
        for (int i = 0; i < 8; i++) begin
            auto_idle = i[0];
            host_i.wr(8'h23, {2'h0, i[2], i[1], 4'h0});
            chk("mute", {7'h0, mute}, {7'h0, i[2] ? i[1] : i[0]});
        end
        chk("term", {7'h0, term}, 8'h00);
        host_i.wr(8'h23, 8'h0c);
        chk("term", {7'h0, term}, 8'h01);
    endtask : t_mute
    // Signal-detect force bits against the raw detector.
    task automatic t_force();
        for (int i = 0; i < 8; i++) begin
            raw_det = i[0];
            host_i.wr(8'h22, {5'h0, i[2], i[1], 1'b0});
            chk("detect", {5'h0, foff, fon, sdet},
                {5'h0, i[2], i[1], ~i[2] & (i[1] | i[0])});
        end
    endtask : t_force
    // Probing policies: a limited window, then an endless one that finds a receiver.
    task automatic t_probe();
        int k = 0;
        host_i.wr(8'h23, 8'h04);
        count_probes(120, 8'h03);
        chk("term", {7'h0, term}, 8'h00);
        host_i.wr(8'h23, 8'h08);
        count_probes(110, 8'h05);
        host_i.present = 1'b1;
        while (found !== 1'b1 && k < 40) begin
            @(negedge sys_clk);
            k++;
        end
        if (k == 40) begin
            n_errors++;
            stop_test();
        end
        chk("term", {7'h0, term}, 8'h01);
        rchk(8'h26, 8'h87);
    endtask : t_probe
    initial begin
        repeat (8) @(negedge sys_clk);
        arst_n = 1'b1;
        t_reset_load();
        t_fields();
        t_mute();
        t_force();
        t_probe();
        stop_test();
    end
endmodule : rlc_lane_regs_test
